//--- rtl/mas_pkg.sv
/*
  Constants and carrier types shared by the media advance stepper block.
  Assumes a 100 MHz system clock and byte-wide registers on a 16-bit address bus.
*/
package mas_pkg;
  // register addresses
  localparam logic [15:0] MAS_FFC_ADDR = 16'hFDC0;
  localparam logic [15:0] MAS_WIND_ADDR = 16'hFDC1;
  localparam logic [15:0] MAS_JSA_ADDR = 16'hFDC2;
  // field positions
  localparam int MAS_FLAG_BIT = 7;
  localparam int MAS_STAT_BIT = 6;
  localparam int MAS_WIND_W = 4;
  localparam int MAS_JS_DIV_W = 5;
  localparam int MAS_JS_DIV = 32;
  // reset values
  localparam logic [3:0] MAS_WIND_RST = 4'h0;
  localparam logic [7:0] MAS_RDATA_RST = 8'h00;
  localparam logic [4:0] MAS_JS_DIV_RST = 5'h00;
  // timing
  localparam int MAS_CLK_PERIOD_NS = 10;
  localparam int MAS_ADV_PERIOD_MS = 1;
  localparam int MAS_DRIVE_HOLD_MS = 50;
  localparam int MAS_PAPER_TIMEOUT_MS = 500;
  localparam int MAS_NS_PER_MS = 1000000;
  localparam int MAS_ADV_CYC = MAS_ADV_PERIOD_MS * MAS_NS_PER_MS / MAS_CLK_PERIOD_NS;
  localparam int MAS_DRIVE_CYC = MAS_DRIVE_HOLD_MS * MAS_NS_PER_MS / MAS_CLK_PERIOD_NS;
  localparam int MAS_PAPER_CYC = MAS_PAPER_TIMEOUT_MS * MAS_NS_PER_MS / MAS_CLK_PERIOD_NS;

  typedef struct packed {
    logic [15:0] addr;
    logic write_n;
    logic transfer_strobe_n;
    logic [7:0] wdata;
  } mas_bus_s;

  typedef struct packed {
    logic ff_mask;
    logic ff_flag;
    logic [31:0] adv_cnt;
    logic js_mask;
    logic js_flag;
    logic js_dir;
    logic [4:0] js_div;
    logic rate_d;
    logic strb_d;
    logic [3:0] winding;
    logic oop;
    logic [7:0] rdata;
    logic irq_n;
  } mas_state_s;
endpackage

//--- rtl/mas_retrig_timer.sv
/*
  Retriggerable one-shot timer: running stays high for COUNT cycles after the last trigger.
  Assumes trigger is synchronous to sys_clk.
*/
`timescale 1ns/1ps
module mas_retrig_timer #(
  parameter int COUNT = 16,
  parameter bit ARMED_AT_RESET = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trigger,
  output logic running
);
  typedef struct packed {
    logic [31:0] left;
    logic run;
  } mas_tmr_s;

  localparam logic [31:0] LOAD = 32'(COUNT);
  localparam mas_tmr_s RST_VAL = ARMED_AT_RESET ? mas_tmr_s'{left: LOAD, run: 1'b1} :
    mas_tmr_s'{left: 32'h0, run: 1'b0};

  mas_tmr_s st_r;
  mas_tmr_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (trigger) begin
      st_nxt.left = LOAD;
    end else if (st_r.left != 32'h0) begin
      st_nxt.left = st_r.left - 32'h1;
    end
    st_nxt.run = (st_nxt.left != 32'h0);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign running = st_r.run;
endmodule

//--- rtl/mas_media_advance.sv
/*
  Media advance stepper controller: advance clock, joystick divider, winding register,
  drive timer and out-of-paper capture behind three byte registers.
  Assumes bus inputs and pins are synchronous to sys_clk; one access per strobe assertion.
*/
// Summary of operation
// - control bit 7 reads advance clock flag, set every 1 ms, level 6.
// - advance flag clears on control read, reset, or mask written zero.
// - control bit 7 write enables advance clock and flag; reset clears it.
// - control bit 6 reads out-of-paper; bits 0 to 5 read zero.
// - winding register write-only; bits 0-3 drive windings, 4-7 ignored.
// - joystick bit 7 reads incremental flag; clears on read, reset, mask zero.
// - joystick bit 7 write enables rate interrupts; reset clears mask and divider.
// - joystick bit 6 reports deflection direction captured with the request.
// - joystick rate pulses divided by 32; each divided pulse raises request while joystick mask set.
// - each winding write retriggers 50 ms full-drive timer.
// - with no winding write for 50 ms, full drive drops to holding.
// - 0.5 s paper-motion timer restarts on each sprocket pulse.
// - paper timeout sampled into status only on winding register write.
// - after motor stops, later timeout is not captured; status keeps its last sampled value.
// - write-select picks read or write path; data strobe qualifies transfer.
`timescale 1ns/1ps
module mas_media_advance import mas_pkg::*; #(
  parameter int ADV_CYC = MAS_ADV_CYC,
  parameter int DRIVE_CYC = MAS_DRIVE_CYC,
  parameter int PAPER_CYC = MAS_PAPER_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire mas_bus_s bus,
  input wire logic joystick_rate_pulse_n,
  input wire logic joystick_positive_dir,
  input wire logic sprocket_pulse,
  output logic [7:0] read_data,
  output logic irq_level6_n,
  output logic [3:0] winding_drive,
  output logic full_drive
);
  localparam mas_state_s RST_STATE = '{
    ff_mask: 1'b0, ff_flag: 1'b0, adv_cnt: 32'h0,
    js_mask: 1'b0, js_flag: 1'b0, js_dir: 1'b0, js_div: MAS_JS_DIV_RST,
    rate_d: 1'b1, strb_d: 1'b1, winding: MAS_WIND_RST, oop: 1'b0,
    rdata: MAS_RDATA_RST, irq_n: 1'b1};
  localparam logic [31:0] ADV_LAST = 32'(ADV_CYC - 1);
  localparam logic [4:0] JS_DIV_LAST = 5'(MAS_JS_DIV - 1);

  mas_state_s st_r;
  mas_state_s st_nxt;
  logic take;
  logic rd_ffc;
  logic rd_jsa;
  logic wr_ffc;
  logic wr_wind;
  logic wr_jsa;
  logic adv_tick;
  logic rate_fall;
  logic js_set;
  logic paper_running;

  // one access per strobe assertion, direction from write-select
  assign take = st_r.strb_d & ~bus.transfer_strobe_n;
  assign rd_ffc = take & bus.write_n & (bus.addr == MAS_FFC_ADDR);
  assign rd_jsa = take & bus.write_n & (bus.addr == MAS_JSA_ADDR);
  assign wr_ffc = take & ~bus.write_n & (bus.addr == MAS_FFC_ADDR);
  assign wr_wind = take & ~bus.write_n & (bus.addr == MAS_WIND_ADDR);
  assign wr_jsa = take & ~bus.write_n & (bus.addr == MAS_JSA_ADDR);

  assign adv_tick = st_r.ff_mask & (st_r.adv_cnt == ADV_LAST);
  assign rate_fall = st_r.rate_d & ~joystick_rate_pulse_n;
  assign js_set = rate_fall & (st_r.js_div == JS_DIV_LAST) & st_r.js_mask;

  mas_retrig_timer #(
    .COUNT(DRIVE_CYC),
    .ARMED_AT_RESET(1'b0)
  ) u_drive_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trigger(wr_wind),
    .running(full_drive)
  );

  // armed at reset so the first winding write does not report a false timeout
  mas_retrig_timer #(
    .COUNT(PAPER_CYC),
    .ARMED_AT_RESET(1'b1)
  ) paper_motion_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .trigger(sprocket_pulse),
    .running(paper_running)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.strb_d = bus.transfer_strobe_n;
    st_nxt.rate_d = joystick_rate_pulse_n;
    // advance clock, held at zero while masked
    if (!st_r.ff_mask || adv_tick) begin
      st_nxt.adv_cnt = 32'h0;
    end else begin
      st_nxt.adv_cnt = st_r.adv_cnt + 32'h1;
    end
    if (wr_ffc) begin
      st_nxt.ff_mask = bus.wdata[MAS_FLAG_BIT];
    end
    // set wins over read or mask clear
    st_nxt.ff_flag = adv_tick | (st_r.ff_flag & ~(rd_ffc | (wr_ffc & ~bus.wdata[MAS_FLAG_BIT])));
    // joystick divider and request
    if (rate_fall) begin
      st_nxt.js_div = st_r.js_div + 5'h01;
    end
    if (wr_jsa) begin
      st_nxt.js_mask = bus.wdata[MAS_FLAG_BIT];
    end
    st_nxt.js_flag = js_set | (st_r.js_flag & ~(rd_jsa | (wr_jsa & ~bus.wdata[MAS_FLAG_BIT])));
    if (js_set) begin
      st_nxt.js_dir = joystick_positive_dir;
    end
    // winding write also samples the paper timeout
    if (wr_wind) begin
      st_nxt.winding = bus.wdata[MAS_WIND_W-1:0];
      st_nxt.oop = ~paper_running;
    end
    if (take && bus.write_n) begin
      if (bus.addr == MAS_FFC_ADDR) begin
        st_nxt.rdata = {st_r.ff_flag, st_r.oop, 6'h00};
      end else if (bus.addr == MAS_JSA_ADDR) begin
        st_nxt.rdata = {st_r.js_flag, st_r.js_dir, 6'h00};
      end else begin
        st_nxt.rdata = MAS_RDATA_RST;
      end
    end
    st_nxt.irq_n = ~(st_nxt.ff_flag | st_nxt.js_flag);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign read_data = st_r.rdata;
  assign irq_level6_n = st_r.irq_n;
  assign winding_drive = st_r.winding;

  adv_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    adv_tick |=> (st_r.ff_flag && !irq_level6_n))
    else $error("advance tick did not raise flag and request");

  adv_read_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_ffc && !adv_tick) |=> !st_r.ff_flag)
    else $error("advance flag not cleared by read");

  adv_mask_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ffc && !bus.wdata[MAS_FLAG_BIT] && !adv_tick) |=> (!st_r.ff_mask && !st_r.ff_flag) ##1 !st_r.ff_flag)
    else $error("masked advance clock still flags");

  ffc_read_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_ffc |=> (read_data[5:0] == 6'h00 && read_data[MAS_STAT_BIT] == $past(st_r.oop)))
    else $error("control read shows wrong status");

  wind_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_wind |=> (winding_drive == $past(bus.wdata[3:0])))
    else $error("winding register not loaded");

  js_request_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    js_set |=> (st_r.js_flag && st_r.js_dir == $past(joystick_positive_dir)))
    else $error("divided rate pulse did not raise request");

  js_read_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (rd_jsa && !js_set) |=> !st_r.js_flag)
    else $error("joystick flag not cleared by read");

  drive_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_wind |=> full_drive [*8])
    else $error("full drive not held after winding write");

  oop_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_wind |=> (st_r.oop == !$past(paper_running)))
    else $error("out-of-paper not sampled on winding write");

  oop_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_wind |=> $stable(st_r.oop))
    else $error("out-of-paper changed without winding write");

  adv_mask_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_ffc && bus.wdata[MAS_FLAG_BIT]) |=> st_r.ff_mask)
    else $error("advance clock not enabled by mask write");

  adv_masked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!st_r.ff_mask && !st_r.ff_flag) |=> !st_r.ff_flag)
    else $error("masked advance clock raised flag");

  js_mask_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_jsa && !bus.wdata[MAS_FLAG_BIT] && !js_set) |=> !st_r.js_flag)
    else $error("joystick flag not cleared by mask write");

  js_masked_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!st_r.js_mask && !st_r.js_flag) |=> !st_r.js_flag)
    else $error("masked rate pulses raised request");

  js_dir_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !js_set |=> $stable(st_r.js_dir))
    else $error("direction changed without request");

  jsa_read_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_jsa |=> (read_data == {$past(st_r.js_flag), $past(st_r.js_dir), 6'h00}))
    else $error("joystick read shows wrong bits");

  wind_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !wr_wind |=> $stable(winding_drive))
    else $error("winding register changed without write");

  drive_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!full_drive && !wr_wind) |=> !full_drive)
    else $error("full drive returned without winding write");
endmodule

//--- test/mas_pulse_src.sv
/*
  Joystick rate pulse and sprocket hole source for the stepper bench.
  Assumes its tasks are called from the bench's single main process.
*/
`timescale 1ns/1ps
module mas_pulse_src (
  input wire logic sys_clk,
  output logic joystick_rate_pulse_n,
  output logic joystick_positive_dir,
  output logic sprocket_pulse
);
  initial begin
    joystick_rate_pulse_n = 1'b1;
    joystick_positive_dir = 1'b0;
    sprocket_pulse = 1'b0;
  end
  // each rate pulse is two cycles low then three high
  task automatic rate(input int n, input logic dir);
    repeat (n) begin
      @(posedge sys_clk) begin
        joystick_positive_dir <= dir;
        joystick_rate_pulse_n <= 1'b0;
      end
      repeat (2) @(posedge sys_clk);
      joystick_rate_pulse_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
    #1;
  endtask
  task automatic sprocket();
    @(posedge sys_clk) sprocket_pulse <= 1'b1;
    @(posedge sys_clk) sprocket_pulse <= 1'b0;
  endtask
endmodule

//--- test/mas_media_advance_test.sv
/*
  Self-checking bench for the media advance stepper, acting as the host.
  Assumes short timer parameters so the run stays brief.
*/
`timescale 1ns/1ps
module mas_media_advance_test;
  import mas_pkg::*;
  localparam int ADV = 100;
  localparam int DRV = 100;
  localparam int PAP = 300;
  logic sys_clk;
  logic rst_n;
  mas_bus_s bus;
  logic rate_n;
  logic pos_dir;
  logic sprocket;
  logic [7:0] read_data;
  logic [7:0] rd;
  logic irq_level6_n;
  logic full_drive;
  logic [3:0] winding_drive;
  logic [7:0] cw [4] = '{8'h03, 8'h09, 8'h0C, 8'h06};
  logic [7:0] ccw [4] = '{8'h03, 8'h06, 8'h0C, 8'h09};
  // ticks that carry a step: sparse at start and end of a feed
  logic [10:0] ramp = 11'h4F9;
  int cycle = 0;
  int irq_at = 0;
  int last_at = 0;
  int steps = 0;
  int errors = 0;
  int comparisons = 0;
  mas_media_advance #(.ADV_CYC(ADV), .DRIVE_CYC(DRV), .PAPER_CYC(PAP)) mas_media_advance_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .joystick_rate_pulse_n(rate_n),
    .joystick_positive_dir(pos_dir), .sprocket_pulse(sprocket), .read_data(read_data),
    .irq_level6_n(irq_level6_n), .winding_drive(winding_drive), .full_drive(full_drive)
  );
  mas_pulse_src mas_pulse_src_inst (
    .sys_clk(sys_clk), .joystick_rate_pulse_n(rate_n), .joystick_positive_dir(pos_dir),
    .sprocket_pulse(sprocket)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cycle <= cycle + 1;
  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // strobe falls, is taken and answered at the next edge, read one edge later
  task automatic access(input logic [15:0] a, input logic wn, input logic [7:0] d);
    @(posedge sys_clk) begin
      bus.addr <= a;
      bus.write_n <= wn;
      bus.wdata <= d;
      bus.transfer_strobe_n <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
    bus.transfer_strobe_n <= 1'b1;
    #1 rd = read_data;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    access(a, 1'b0, d);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    access(a, 1'b1, 8'h00);
    check(rd, exp);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 2 * ADV && irq_level6_n !== 1'b0; i++) idle(1);
    last_at = irq_at;
    irq_at = cycle;
    if (irq_level6_n !== 1'b0) begin
      check({7'h00, irq_level6_n}, 8'h00);
      final_report();
    end
  endtask
  task automatic do_reset();
    @(posedge sys_clk) rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    idle(1);
  endtask
  initial begin
    rst_n = 1'b0;
    bus = {16'h0000, 1'b1, 1'b1, 8'h00};
    do_reset();
    check({irq_level6_n, full_drive, 2'h0, winding_drive}, 8'h80);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    rd_chk(MAS_JSA_ADDR, 8'h00);
    rd_chk(MAS_WIND_ADDR, 8'h00);
    rd_chk(16'hFDC3, 8'h00);
    $display("test reset finished");
    wr(MAS_FFC_ADDR, 8'h80);
    wait_irq();
    rd_chk(MAS_FFC_ADDR, 8'h80);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    wait_irq();
    wr(MAS_FFC_ADDR, 8'h00);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    idle(2 * ADV);
    check({7'h00, irq_level6_n}, 8'h01);
    $display("test advance clock finished");
    wr(MAS_WIND_ADDR, 8'hF3);
    check({3'h0, full_drive, winding_drive}, 8'h13);
    for (int i = 0; i < 4; i++) begin
      wr(MAS_WIND_ADDR, cw[i]);
      check({4'h0, winding_drive}, cw[i]);
    end
    idle(DRV - 20);
    wr(MAS_WIND_ADDR, 8'h03);
    idle(DRV - 20);
    check({7'h00, full_drive}, 8'h01);
    idle(30);
    check({3'h0, full_drive, winding_drive}, 8'h03);
    $display("test drive timer finished");
    mas_pulse_src_inst.sprocket();
    wr(MAS_WIND_ADDR, 8'h03);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    idle(PAP + 20);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    wr(MAS_WIND_ADDR, 8'h06);
    rd_chk(MAS_FFC_ADDR, 8'h40);
    mas_pulse_src_inst.sprocket();
    wr(MAS_WIND_ADDR, 8'h0C);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    $display("test paper finished");
    wr(MAS_FFC_ADDR, 8'h80);
    for (int k = 0; k < 11; k++) begin
      wait_irq();
      if (k > 0) check(8'(irq_at - last_at), 8'(ADV));
      rd_chk(MAS_FFC_ADDR, 8'h80);
      mas_pulse_src_inst.sprocket();
      if (ramp[k]) begin
        wr(MAS_WIND_ADDR, ccw[steps % 4]);
        check({3'h0, full_drive, winding_drive}, 8'h10 | ccw[steps % 4]);
        steps++;
      end
    end
    wr(MAS_FFC_ADDR, 8'h00);
    rd_chk(MAS_FFC_ADDR, 8'h00);
    $display("test form feed finished");
    mas_pulse_src_inst.rate(16, 1'b1);
    do_reset();
    wr(MAS_JSA_ADDR, 8'h80);
    mas_pulse_src_inst.rate(31, 1'b1);
    rd_chk(MAS_JSA_ADDR, 8'h00);
    mas_pulse_src_inst.rate(1, 1'b1);
    check({7'h00, irq_level6_n}, 8'h00);
    rd_chk(MAS_JSA_ADDR, 8'hC0);
    rd_chk(MAS_JSA_ADDR, 8'h40);
    mas_pulse_src_inst.rate(32, 1'b0);
    wr(MAS_JSA_ADDR, 8'h00);
    rd_chk(MAS_JSA_ADDR, 8'h00);
    mas_pulse_src_inst.rate(32, 1'b1);
    rd_chk(MAS_JSA_ADDR, 8'h00);
    $display("test joystick finished");
    final_report();
  end
endmodule
